/* File: core/sbc_cmd.sv */
// Serial boot command interpreter: ID check, read check data, baud changes
// Summary of operation
// - With flash not blank, received ID bytes are compared with ID bytes stored in flash.
// - Until an ID match succeeds, commands that need a verified identity are refused; a later failed match does not undo it.
// - ID bytes are 8 bits each, fetched from fixed flash addresses starting at 0FFFDF.
// - Read check data takes opcode FD, then returns checksum low byte and then high byte.
// - The checksum covers write data bytes received by page program commands.
// - Read check data latches the current checksum and clears the accumulator in the same cycle, before sending.
// - Each write byte is added singly; the report is the two's complement of the low 16 bits.
// - Opcode B0 is echoed, and only then the rate becomes 9600 bps.
// - Opcode B1 is echoed, and then the rate becomes 19200 bps.
// - Opcode B2 is echoed, and then the rate becomes 38400 bps.
// - Opcode B3 is echoed, and then the rate becomes 57600 bps.
// - With flash entirely blank every command is accepted.
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_cmd (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sbc_pkg::sbc_byte_s rx_byte,
    input wire logic tx_ready,
    input wire logic tx_done,
    input wire logic flash_blank,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_rvalid,
    output sbc_pkg::sbc_byte_s tx_byte_q,
    output sbc_pkg::sbc_fetch_s fetch_q,
    output sbc_pkg::sbc_baud_e baud_q,
    output logic id_verified_q,
    output logic cmd_refused_q,
    output logic pp_byte_q
);
    typedef enum {
        S_IDLE, S_ID_ADDR, S_ID_LEN, S_ID_DATA, S_ID_FETCH, S_PP_ADDR, S_PP_DATA,
        S_CK_LOW, S_CK_HIGH, S_ECHO, S_ECHO_WAIT, S_SKIP
    } sbc_state_e;
    sbc_state_e state_q;
    logic [1:0] cnt_q;
    logic [8:0] pp_cnt_q;
    logic [2:0] id_len_q;
    logic [2:0] id_idx_q;
    logic [7:0] id_rx_q;
    logic id_ok_q;
    logic [15:0] acc_q;
    logic [15:0] check_q;
    logic [1:0] pend_baud_q;
    logic [7:0] op_q;
    logic allowed;
    logic [23:0] id_addr;
    logic [2:0] next_idx;

    assign allowed = flash_blank | id_verified_q;
    assign next_idx = id_idx_q + 3'h1;

    // fixed storage addresses looked up by index; indices 2-3 share THIRD, 4 and up share LAST
    always_comb begin
        case (id_idx_q)
            3'h0: id_addr = `SBC_ID_ADDR_FIRST;
            3'h1: id_addr = `SBC_ID_ADDR_SECOND;
            3'h2, 3'h3: id_addr = `SBC_ID_ADDR_THIRD;
            default: id_addr = `SBC_ID_ADDR_LAST;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            cnt_q <= 2'h0;
            pp_cnt_q <= 9'h000;
            id_len_q <= 3'h0;
            id_idx_q <= 3'h0;
            id_rx_q <= 8'h00;
            id_ok_q <= 1'b0;
            pend_baud_q <= `SBC_BAUD_RESET;
            op_q <= 8'h00;
            tx_byte_q <= '0;
            fetch_q <= '0;
            cmd_refused_q <= 1'b0;
        end else begin
            tx_byte_q.valid <= 1'b0;
            cmd_refused_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (rx_byte.valid) begin
                        op_q <= rx_byte.data;
                        cnt_q <= 2'h0;
                        case (rx_byte.data)
                            // F5 is followed by three address bytes
                            `SBC_OP_ID_CHECK: state_q <= S_ID_ADDR;
                            `SBC_OP_PAGE_PROG: begin
                                if (allowed) begin
                                    state_q <= S_PP_ADDR;
                                end else begin
                                    cmd_refused_q <= 1'b1;
                                end
                            end
                            `SBC_OP_READ_CHECK: begin
                                if (allowed) begin
                                    state_q <= S_CK_LOW;
                                end else begin
                                    cmd_refused_q <= 1'b1;
                                end
                            end
                            `SBC_OP_BAUD_9600, `SBC_OP_BAUD_19200,
                            `SBC_OP_BAUD_38400, `SBC_OP_BAUD_57600: begin
                                pend_baud_q <= rx_byte.data[1:0];
                                state_q <= S_ECHO;
                            end
                            default: begin
                                if (!allowed) begin
                                    cmd_refused_q <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                S_ID_ADDR: begin
                    if (rx_byte.valid) begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == 2'h2) begin
                            state_q <= S_ID_LEN;
                        end
                    end
                end
                S_ID_LEN: begin
                    if (rx_byte.valid) begin
                        id_len_q <= (rx_byte.data > `SBC_ID_LEN_MAX) ? 3'h7 : rx_byte.data[2:0];
                        id_idx_q <= 3'h0;
                        id_ok_q <= (rx_byte.data == `SBC_ID_LEN_MAX);
                        state_q <= (rx_byte.data == 8'h00) ? S_IDLE : S_ID_DATA;
                    end
                end
                S_ID_DATA: begin
                    // one byte element fetched per received code byte
                    if (rx_byte.valid) begin
                        id_rx_q <= rx_byte.data;
                        fetch_q.addr <= id_addr;
                        fetch_q.req <= 1'b1;
                        state_q <= S_ID_FETCH;
                    end
                end
                S_ID_FETCH: begin
                    fetch_q.req <= 1'b0;
                    if (flash_rvalid) begin
                        if (flash_rdata != id_rx_q) begin
                            id_ok_q <= 1'b0;
                        end
                        id_idx_q <= next_idx;
                        state_q <= (next_idx == id_len_q) ? S_IDLE : S_ID_DATA;
                    end
                end
                S_PP_ADDR: begin
                    if (rx_byte.valid) begin
                        cnt_q <= cnt_q + 2'h1;
                        pp_cnt_q <= 9'h000;
                        if (cnt_q == 2'h1) begin
                            state_q <= S_PP_DATA;
                        end
                    end
                end
                S_PP_DATA: begin
                    if (rx_byte.valid) begin
                        pp_cnt_q <= pp_cnt_q + 9'h001;
                        if (pp_cnt_q == `SBC_PAGE_BYTES - 9'h001) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_CK_LOW: begin
                    if (tx_ready) begin
                        tx_byte_q.data <= check_q[7:0];
                        tx_byte_q.valid <= 1'b1;
                        state_q <= S_CK_HIGH;
                    end
                end
                S_CK_HIGH: begin
                    if (tx_ready && !tx_byte_q.valid) begin
                        tx_byte_q.data <= check_q[15:8];
                        tx_byte_q.valid <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_ECHO: begin
                    if (tx_ready) begin
                        tx_byte_q.data <= op_q;
                        tx_byte_q.valid <= 1'b1;
                        state_q <= S_ECHO_WAIT;
                    end
                end
                // wait for stop bit before switching
                S_ECHO_WAIT: begin
                    if (tx_done) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // flag set on full match, held until reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            id_verified_q <= 1'b0;
        end else if (state_q == S_ID_FETCH && flash_rvalid && next_idx == id_len_q && id_len_q == 3'h7
                     && id_ok_q && flash_rdata == id_rx_q && !flash_blank) begin
            id_verified_q <= 1'b1;
        end
    end

    // cleared once the checksum is latched for sending
    // byte-wise sum, reported as two's complement
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_q <= 16'h0000;
            check_q <= 16'h0000;
            pp_byte_q <= 1'b0;
        end else begin
            pp_byte_q <= (state_q == S_PP_DATA) && rx_byte.valid;
            if (state_q == S_IDLE && rx_byte.valid && rx_byte.data == `SBC_OP_READ_CHECK && allowed) begin
                check_q <= 16'h0000 - acc_q;
                acc_q <= 16'h0000;
            end else if (state_q == S_PP_DATA && rx_byte.valid) begin
                acc_q <= acc_q + {8'h00, rx_byte.data};
            end
        end
    end

    // rate switched only after echo completes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            baud_q <= sbc_pkg::SBC_BAUD_9600;
        end else if (state_q == S_ECHO_WAIT && tx_done) begin
            baud_q <= sbc_pkg::sbc_baud_e'(pend_baud_q);
        end
    end

    // Assertions
    a_baud_after_echo: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(baud_q) |-> $past(state_q) == S_ECHO_WAIT && $past(tx_done))
        else $error("baud changed without completed echo");
    a_echo_matches_op: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_ECHO && tx_ready) |=> tx_byte_q.valid && tx_byte_q.data == op_q)
        else $error("echo byte differs from opcode");
    a_refuse_unverified: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_IDLE && rx_byte.valid && rx_byte.data == `SBC_OP_PAGE_PROG && !allowed)
        |=> cmd_refused_q && state_q == S_IDLE)
        else $error("restricted command not refused");
    a_blank_accepts: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_IDLE && rx_byte.valid && rx_byte.data == `SBC_OP_READ_CHECK && flash_blank)
        |=> state_q == S_CK_LOW && !cmd_refused_q)
        else $error("blank flash refused a command");
    a_check_clear: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_CK_LOW) |-> acc_q == 16'h0000 || $past(state_q) != S_IDLE)
        else $error("accumulator not cleared by read check");
    a_check_twos: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_IDLE && rx_byte.valid && rx_byte.data == `SBC_OP_READ_CHECK && allowed)
        |=> check_q + $past(acc_q) == 16'h0000)
        else $error("check data not two's complement");
    a_check_order: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_CK_LOW && tx_ready) |=> tx_byte_q.data == check_q[7:0] ##[1:20] state_q == S_IDLE)
        else $error("check data order wrong");
    a_pp_sum: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_PP_DATA && rx_byte.valid) |=> acc_q == $past(acc_q) + {8'h00, $past(rx_byte.data)})
        else $error("page byte not accumulated");
    a_id_first_addr: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_ID_DATA && rx_byte.valid && id_idx_q == 3'h0) |=> fetch_q.addr == `SBC_ID_ADDR_FIRST)
        else $error("first ID address wrong");
    a_id_mismatch: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == S_ID_FETCH && flash_rvalid && flash_rdata != id_rx_q && !id_verified_q) |=> !id_verified_q)
        else $error("mismatched ID verified");
endmodule : sbc_cmd

/* File: core/sbc_defines.svh */
// Constants for the serial boot ID check, checksum and baud-rate commands
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
`define SBC_OP_ID_CHECK 8'hF5
`define SBC_OP_READ_CHECK 8'hFD
`define SBC_OP_PAGE_PROG 8'h41
`define SBC_OP_BAUD_9600 8'hB0
`define SBC_OP_BAUD_19200 8'hB1
`define SBC_OP_BAUD_38400 8'hB2
`define SBC_OP_BAUD_57600 8'hB3
`define SBC_ID_ADDR_FIRST 24'h0FFFDF
`define SBC_ID_ADDR_SECOND 24'h0FFFE3
`define SBC_ID_ADDR_THIRD 24'h0FFFEB
`define SBC_ID_ADDR_LAST 24'h0FFFFB
`define SBC_ID_LEN_MAX 8'h07
`define SBC_PAGE_BYTES 9'h100
`define SBC_BAUD_RESET 2'h0
`endif

/* File: core/sbc_pkg.sv */
// Types shared by the serial boot command block
package sbc_pkg;
    typedef enum logic [1:0] {
        SBC_BAUD_9600,
        SBC_BAUD_19200,
        SBC_BAUD_38400,
        SBC_BAUD_57600
    } sbc_baud_e;
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } sbc_byte_s;
    typedef struct packed {
        logic [23:0] addr;
        logic req;
    } sbc_fetch_s;
endpackage : sbc_pkg

/* File: tb/sbc_peer.sv */
// Model of the byte transmitter and flash ID store beside the command block
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_peer (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sbc_pkg::sbc_byte_s tx_byte_q,
    input wire sbc_pkg::sbc_fetch_s fetch_q,
    output logic tx_ready,
    output logic tx_done,
    output logic [7:0] flash_rdata,
    output logic flash_rvalid
);
    logic [3:0] tx_cnt_q;
    logic [1:0] fl_cnt_q;
    logic [23:0] fl_addr_q;
    function automatic logic [7:0] id_at(input logic [23:0] a);
        case (a)
            `SBC_ID_ADDR_FIRST: return 8'h3C;
            `SBC_ID_ADDR_SECOND: return 8'h5A;
            `SBC_ID_ADDR_THIRD: return 8'hA5;
            default: return 8'hC3;
        endcase
    endfunction : id_at
    // Random busy span; a byte offered while busy is lost, as on the real line
    always_ff @(posedge ref_clk) begin
        tx_done <= 1'b0;
        if (reset) begin
            tx_ready <= 1'b1;
            tx_cnt_q <= 4'h0;
        end else if (tx_cnt_q != 4'h0) begin
            tx_cnt_q <= tx_cnt_q - 4'h1;
            if (tx_cnt_q == 4'h1) begin
                tx_ready <= 1'b1;
                tx_done <= 1'b1;
            end
        end else if (tx_byte_q.valid && tx_ready) begin
            tx_ready <= 1'b0;
            tx_cnt_q <= 4'h3 + 4'($urandom % 8);
        end
    end
    // Idle data line toggles so stale bytes never look valid
    always_ff @(posedge ref_clk) begin
        flash_rvalid <= 1'b0;
        flash_rdata <= ~flash_rdata;
        if (reset) begin
            fl_cnt_q <= 2'h0;
            flash_rdata <= 8'h00;
        end else if (fetch_q.req) begin
            fl_cnt_q <= 2'h2;
            fl_addr_q <= fetch_q.addr;
        end else if (fl_cnt_q != 2'h0) begin
            fl_cnt_q <= fl_cnt_q - 2'h1;
            if (fl_cnt_q == 2'h1) begin
                flash_rvalid <= 1'b1;
                flash_rdata <= id_at(fl_addr_q);
            end
        end
    end
endmodule : sbc_peer

/* File: tb/sbc_cmd_test.sv */
// Self-checking bench for the serial boot command block
`timescale 1ns/1ps
`include "sbc_defines.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, (ex), (got)); end end
module sbc_cmd_test;
    logic ref_clk, reset, flash_blank, tx_ready, tx_done, flash_rvalid, id_verified_q, cmd_refused_q, pp_byte_q;
    logic [7:0] flash_rdata;
    sbc_pkg::sbc_byte_s rx_byte, tx_byte_q;
    sbc_pkg::sbc_fetch_s fetch_q;
    sbc_pkg::sbc_baud_e baud_q;
    int errors = 0, total_checks = 0, cycles = 0, n_ref = 0, n_pp = 0;
    logic [7:0] txq[$];
    logic [23:0] fq[$];
    logic [15:0] sum;
    logic [7:0] idc[7] = '{8'h3C, 8'h5A, 8'hA5, 8'hA5, 8'hC3, 8'hC3, 8'hC3};
    logic [23:0] ida[7] = '{`SBC_ID_ADDR_FIRST, `SBC_ID_ADDR_SECOND, `SBC_ID_ADDR_THIRD, `SBC_ID_ADDR_THIRD,
        `SBC_ID_ADDR_LAST, `SBC_ID_ADDR_LAST, `SBC_ID_ADDR_LAST};
    logic [7:0] bop[4] = '{`SBC_OP_BAUD_57600, `SBC_OP_BAUD_19200, `SBC_OP_BAUD_38400, `SBC_OP_BAUD_9600};
    sbc_pkg::sbc_baud_e bv[4] = '{sbc_pkg::SBC_BAUD_57600, sbc_pkg::SBC_BAUD_19200, sbc_pkg::SBC_BAUD_38400,
        sbc_pkg::SBC_BAUD_9600};
    logic [7:0] rop[3] = '{`SBC_OP_PAGE_PROG, `SBC_OP_READ_CHECK, 8'h77};
    sbc_cmd dut (.ref_clk(ref_clk), .reset(reset), .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_done(tx_done),
        .flash_blank(flash_blank), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .tx_byte_q(tx_byte_q),
        .fetch_q(fetch_q), .baud_q(baud_q), .id_verified_q(id_verified_q), .cmd_refused_q(cmd_refused_q),
        .pp_byte_q(pp_byte_q));
    sbc_peer peer (.ref_clk(ref_clk), .reset(reset), .tx_byte_q(tx_byte_q), .fetch_q(fetch_q),
        .tx_ready(tx_ready), .tx_done(tx_done), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            test_done();
        end else if (!reset) begin
            if (tx_byte_q.valid === 1'b1) txq.push_back(tx_byte_q.data);
            if (fetch_q.req === 1'b1) fq.push_back(fetch_q.addr);
            if (cmd_refused_q === 1'b1) n_ref++;
            if (pp_byte_q === 1'b1) n_pp++;
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic send(input logic [7:0] d);
        @(posedge ref_clk);
        rx_byte <= {d, 1'b1};
        @(posedge ref_clk);
        rx_byte <= 9'h000;
    endtask : send
    task automatic do_reset(input logic blank);
        @(posedge ref_clk);
        reset <= 1'b1;
        flash_blank <= blank;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        n_ref = 0;
    endtask : do_reset
    task automatic tx_idle();
        for (int n = 0; n < 40 && tx_ready !== 1'b1; n++) tick();
    endtask : tx_idle
    // Two's complement of the low 16 bits of the byte sum
    function automatic logic [15:0] check_of(input logic [15:0] s);
        return ~s + 16'h0001;
    endfunction : check_of
    task automatic read_check(input logic [15:0] s);
        logic [15:0] ck;
        ck = check_of(s);
        txq.delete();
        send(`SBC_OP_READ_CHECK);
        for (int n = 0; n < 200 && txq.size() < 2; n++) tick();
        `CHK("check low", ck[7:0], txq[0])
        `CHK("check high", ck[15:8], txq[1])
        tx_idle();
    endtask : read_check
    task automatic baud(input logic [7:0] op, input sbc_pkg::sbc_baud_e b);
        sbc_pkg::sbc_baud_e old;
        old = baud_q;
        txq.delete();
        send(op);
        for (int n = 0; n < 200 && tx_done !== 1'b1; n++) begin
            tick();
            `CHK("baud held", old, baud_q)
        end
        tick();
        `CHK("echo", op, txq[0])
        `CHK("baud new", b, baud_q)
    endtask : baud
    task automatic id_check(input int bad);
        logic [23:0] a;
        a = `SBC_ID_ADDR_FIRST;
        fq.delete();
        send(`SBC_OP_ID_CHECK);
        send(a[7:0]);
        send(a[15:8]);
        send(a[23:16]);
        send(`SBC_ID_LEN_MAX);
        for (int i = 0; i < 7; i++) begin
            send(idc[i] ^ ((i == bad) ? 8'h01 : 8'h00));
            for (int n = 0; n < 50 && flash_rvalid !== 1'b1; n++) tick();
            tick();
        end
        tick();
        `CHK("verified", (bad < 0) ? 1'b1 : 1'b0, id_verified_q)
        if (bad < 0) for (int i = 0; i < 7; i++) `CHK("fetch addr", ida[i], fq[i])
    endtask : id_check
    task automatic refuse(input logic [7:0] op);
        int n0;
        n0 = n_ref;
        txq.delete();
        send(op);
        for (int n = 0; n < 20 && n_ref == n0; n++) tick();
        tick();
        `CHK("refused", n0 + 1, n_ref)
        `CHK("no answer", 0, txq.size())
    endtask : refuse
    task automatic page(input logic ones, inout logic [15:0] s);
        logic [7:0] d;
        n_pp = 0;
        send(`SBC_OP_PAGE_PROG);
        send(8'($urandom));
        send(8'($urandom));
        for (int i = 0; i < 256; i++) begin
            d = ones ? 8'hFF : 8'($urandom);
            send(d);
            s = s + 16'(d);
        end
        tick();
        tick();
        `CHK("page bytes", 256, n_pp)
    endtask : page
    initial begin
        reset = 1'b1;
        flash_blank = 1'b0;
        rx_byte = 9'h000;
        void'($urandom(57));
        do_reset(1'b0);
        tick();
        `CHK("baud reset", sbc_pkg::SBC_BAUD_9600, baud_q)
        `CHK("verified reset", 1'b0, id_verified_q)
        for (int i = 0; i < 4; i++) baud(bop[i], bv[i]);
        id_check($urandom % 7);
        for (int i = 0; i < 3; i++) refuse(rop[i]);
        id_check(-1);
        read_check(16'h0000);
        sum = 16'h0000;
        // FF page then a random page carry the sum past 16 bits
        page(1'b1, sum);
        page(1'b0, sum);
        read_check(sum);
        read_check(16'h0000);
        do_reset(1'b1);
        read_check(16'h0000);
        test_done();
    end
endmodule : sbc_cmd_test
